//--- rtl/rx_port_lock_pass_control.v
// receive port control, lock/pass status and forwarding
`timescale 1ns/1ps
`include "rx_port_lock_regs.vh"

// ----
// stream buffer
// ----
module stream_fifo #(
  parameter W  = 15,
  parameter D  = 8,
  parameter AW = 3
)(
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire         in_valid_i,
  input  wire [W-1:0] in_data_i,
  output reg          in_ready_o,
  output reg          out_valid_o,
  output reg  [W-1:0] out_data_o,
  input  wire         out_ready_i
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         push = in_valid_i & in_ready_o;
  wire         load = (count != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);
  wire [AW:0]  next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr      <= {AW{1'b0}};
      rd_ptr      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o  <= {W{1'b0}};
    end
    else
    begin
      count      <= next_count;
      // ready is registered so the source sees a clean stall
      in_ready_o <= (next_count < D);
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (load)
      begin
        out_data_o  <= mem[rd_ptr];
        out_valid_o <= 1'b1;
        rd_ptr      <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      else if (out_ready_i)
        out_valid_o <= 1'b0;
    end
  end
endmodule

// Summary of operation
// - backup timebase drives timers until reference is usable.
// - control register can disable either receive port.
// - only the local serial controller writes port disables.
// - page select picks which port's private registers are reached.
// - each port has its own 7-bit direct address.
// - per-port addresses also reach shared registers.
// - forwarding off after reset until enabled.
// - lock and pass drive pins and device status.
// - selects pick port 0, port 1, OR or AND.
// - lock only after stable synchronization.
// - optional bit-error check for gaining and losing lock.
// - per-port status shows lock; lock gates forwarding.
// - wide high-rate raw mode lock pin needs live pixel clock.
// - linked flag high whenever linked, both raw modes.
// - 10-bit raw mode lock pin follows link alone.
// - linked flags routable to general-purpose outputs.
// - lock loss resets and reruns acquisition.
// - errored frames truncated; forwarding resumes on relock.
// - pass after configured clean frames; forwarding may wait for pass.
module rx_port_lock_pass_control #(
  parameter [6:0] MAIN_ADDR = 7'h30
)(
  input  wire                   clk_i,
  input  wire                   reset_n_i,
  input  wire                   reference_clock_input_i,
  input  wire                   scl_i,
  input  wire                   sda_i,
  output reg                    sda_o,
  output reg                    sda_oe_o,
  input  wire [1:0]             link_signal_i,
  input  wire [1:0]             pclk_active_i,
  input  wire [1:0]             link_bit_err_i,
  input  wire [1:0]             vid_valid_i,
  input  wire [2*12-1:0]        vid_data_i,
  input  wire [1:0]             vid_fs_i,
  input  wire [1:0]             vid_le_i,
  input  wire [1:0]             vid_fe_i,
  output wire [1:0]             vid_ready_o,
  output wire [1:0]             fwd_valid_o,
  output wire [2*`VID_W-1:0]    fwd_data_o,
  input  wire [1:0]             fwd_ready_i,
  output reg                    lock_o,
  output reg                    pass_o,
  output reg  [1:0]             gpio_o,
  output reg                    ref_external_o
);
  localparam I_IDLE = 5'b00001;
  localparam I_RX   = 5'b00010;
  localparam I_ACK  = 5'b00100;
  localparam I_TX   = 5'b01000;
  localparam I_RACK = 5'b10000;
  localparam L_OFF    = 4'b0001;
  localparam L_ACQ    = 4'b0010;
  localparam L_LOCK   = 4'b0100;
  localparam L_RELOCK = 4'b1000;

  // ----
  // timebase
  // ----
  reg  [2:0]  ref_s;
  reg  [11:0] ref_gap;
  reg  [3:0]  bdiv;
  reg         tick;
  wire        ref_edge = ref_s[1] & ~ref_s[2];

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_s          <= 3'h0;
      ref_gap        <= 12'hFFF;
      bdiv           <= 4'h0;
      tick           <= 1'b0;
      ref_external_o <= 1'b0;
    end
    else
    begin
      ref_s <= {ref_s[1:0], reference_clock_input_i};
      if (ref_edge)
        ref_gap <= 12'h000;
      else if (ref_gap != 12'hFFF)
        ref_gap <= ref_gap + 12'h001;
      // a stalled reference falls back to the backup timebase
      ref_external_o <= (ref_gap < `REF_GAP_CYC);
      bdiv <= (bdiv == `BACKUP_DIV - 1) ? 4'h0 : bdiv + 4'h1;
      tick <= ref_external_o ? ref_edge : (bdiv == 4'h0);
    end
  end

  // ----
  // shared registers
  // ----
  reg  [7:0] port_ctl;
  reg  [7:0] fwd_ctl;
  reg  [7:0] page_sel;
  reg  [7:0] gpio_route;
  reg  [6:0] port_id0;
  reg  [6:0] port_id1;
  reg        wr_en;
  reg  [7:0] wr_addr;
  reg  [7:0] wr_data;
  reg  [1:0] wr_mask;
  reg  [1:0] tmask;
  reg  [7:0] ptr;
  reg  [7:0] rd_data;
  wire [1:0] linked;
  wire [1:0] passed;
  wire [1:0] pin_lock;
  wire [15:0] cfg_v;
  wire [3:0] mode_v;
  wire [15:0] sts_v;
  wire       rp = (tmask == 2'b00) ? page_sel[`PAGE_RD_BIT] : tmask[1];

  function sel_src;
    input [1:0] sel;
    input [1:0] v;
    input [1:0] en;
    begin
      case (sel)
        2'b00:   sel_src = v[0];
        2'b01:   sel_src = v[1];
        2'b10:   sel_src = |(v & en);
        default: sel_src = (en != 2'b00) & (&(v | ~en));
      endcase
    end
  endfunction

  wire lock_sel_v = sel_src(port_ctl[`LOCK_SEL_LSB+:2], pin_lock, port_ctl[1:0]);
  wire pass_sel_v = sel_src(port_ctl[`PASS_SEL_LSB+:2], passed, port_ctl[1:0]);

  always @*
  begin
    case (ptr)
      `ADDR_DEV_STS:    rd_data = {5'h00, ref_external_o, pass_sel_v, lock_sel_v};
      `ADDR_PORT_CTL:   rd_data = port_ctl;
      `ADDR_GPIO_ROUTE: rd_data = gpio_route;
      `ADDR_FWD_CTL:    rd_data = fwd_ctl;
      `ADDR_PAGE_SEL:   rd_data = page_sel;
      `ADDR_PORT_STS1:  rd_data = rp ? sts_v[15:8] : sts_v[7:0];
      `ADDR_LOCK_CFG:   rd_data = rp ? cfg_v[15:8] : cfg_v[7:0];
      `ADDR_PORT_MODE:  rd_data = {6'h00, rp ? mode_v[3:2] : mode_v[1:0]};
      `ADDR_PORT0_ID:   rd_data = {port_id0, 1'b0};
      `ADDR_PORT1_ID:   rd_data = {port_id1, 1'b0};
      default:          rd_data = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      port_ctl   <= `RST_PORT_CTL;
      fwd_ctl    <= `RST_FWD_CTL;
      page_sel   <= `RST_PAGE_SEL;
      gpio_route <= `RST_GPIO_ROUTE;
      port_id0   <= `RST_PORT_ID;
      port_id1   <= `RST_PORT_ID;
      lock_o     <= 1'b0;
      pass_o     <= 1'b0;
      gpio_o     <= 2'b00;
    end
    else
    begin
      // only the local serial port writes here
      if (wr_en)
      begin
        case (wr_addr)
          `ADDR_PORT_CTL:   port_ctl   <= wr_data;
          `ADDR_GPIO_ROUTE: gpio_route <= wr_data;
          `ADDR_FWD_CTL:    fwd_ctl    <= wr_data;
          `ADDR_PAGE_SEL:   page_sel   <= wr_data;
          `ADDR_PORT0_ID:   port_id0   <= wr_data[7:1];
          `ADDR_PORT1_ID:   port_id1   <= wr_data[7:1];
          default:          ;
        endcase
      end
      lock_o <= lock_sel_v;
      pass_o <= pass_sel_v;
      gpio_o <= gpio_route[1:0] & linked;
    end
  end

  // ----
  // serial register port
  // ----
  reg  [2:0] scl_s;
  reg  [2:0] sda_s;
  reg  [4:0] ist;
  reg  [3:0] bcnt;
  reg  [7:0] shreg;
  reg  [1:0] bidx;
  reg        rw;
  reg        mack;
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start    = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  wire stop     = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
  wire hit_main = (shreg[7:1] == MAIN_ADDR);
  wire hit_p0   = (port_id0 != 7'h00) & (shreg[7:1] == port_id0);
  wire hit_p1   = (port_id1 != 7'h00) & (shreg[7:1] == port_id1);

  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_s    <= 3'h7;
      sda_s    <= 3'h7;
      ist      <= I_IDLE;
      bcnt     <= 4'h0;
      shreg    <= 8'h00;
      bidx     <= 2'h0;
      rw       <= 1'b0;
      mack     <= 1'b1;
      tmask    <= 2'b00;
      ptr      <= 8'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_en    <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      wr_mask  <= 2'b00;
    end
    else
    begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      wr_en <= 1'b0;
      sda_o <= 1'b0;
      if (start)
      begin
        ist      <= I_RX;
        bcnt     <= 4'h0;
        bidx     <= 2'h0;
        sda_oe_o <= 1'b0;
      end
      else if (stop)
      begin
        ist      <= I_IDLE;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (ist)
          I_IDLE: ;
          I_RX:
          begin
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_s[1]};
              bcnt  <= bcnt + 4'h1;
            end
            else if (scl_fall && bcnt == 4'h8)
            begin
              ist      <= I_ACK;
              sda_oe_o <= 1'b1;
              if (bidx == 2'h0)
              begin
                rw    <= shreg[0];
                tmask <= hit_p0 ? 2'b01 : (hit_p1 ? 2'b10 : 2'b00);
                bidx  <= 2'h1;
                if (!(hit_main | hit_p0 | hit_p1))
                begin
                  ist      <= I_IDLE;
                  sda_oe_o <= 1'b0;
                end
              end
              else if (bidx == 2'h1)
              begin
                ptr  <= shreg;
                bidx <= 2'h2;
              end
              else
              begin
                // private regs go to the page or the port's own
                wr_en   <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                wr_mask <= (tmask == 2'b00) ? page_sel[1:0] : tmask;
                ptr     <= ptr + 8'h01;
              end
            end
          end
          I_ACK:
          begin
            if (scl_fall)
            begin
              bcnt <= 4'h0;
              if (rw)
              begin
                shreg    <= rd_data;
                ptr      <= ptr + 8'h01;
                sda_oe_o <= ~rd_data[7];
                ist      <= I_TX;
              end
              else
              begin
                sda_oe_o <= 1'b0;
                ist      <= I_RX;
              end
            end
          end
          I_TX:
          begin
            if (scl_rise)
              bcnt <= bcnt + 4'h1;
            else if (scl_fall)
            begin
              if (bcnt == 4'h8)
              begin
                sda_oe_o <= 1'b0;
                ist      <= I_RACK;
              end
              else
              begin
                shreg    <= {shreg[6:0], 1'b0};
                sda_oe_o <= ~shreg[6];
              end
            end
          end
          I_RACK:
          begin
            if (scl_rise)
              mack <= sda_s[1];
            else if (scl_fall)
            begin
              bcnt <= 4'h0;
              if (!mack)
              begin
                shreg    <= rd_data;
                ptr      <= ptr + 8'h01;
                sda_oe_o <= ~rd_data[7];
                ist      <= I_TX;
              end
              else
                ist <= I_IDLE;
            end
          end
          default: ist <= I_IDLE;
        endcase
      end
    end
  end

  // ----
  // per-port lock, frame check, forwarding
  // ----
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_port
      reg  [1:0]  ls;
      reg  [1:0]  pa;
      reg  [7:0]  cfg;
      reg  [1:0]  mode;
      reg  [3:0]  lst;
      reg  [8:0]  timer;
      reg         in_frame;
      reg         fwd_frame;
      reg         bad;
      reg  [11:0] llen;
      reg  [11:0] rlen;
      reg  [11:0] lines;
      reg  [11:0] rlines;
      reg  [3:0]  good;
      reg         pass;
      wire        in_rdy;
      wire        lk = (lst == L_LOCK);
      wire        err_now = link_bit_err_i[p] & cfg[`CFG_ERRCHK_BIT];
      wire        hs = vid_valid_i[p] & in_rdy;
      wire        fs = vid_fs_i[p];
      wire        le = vid_le_i[p];
      wire        fe = vid_fe_i[p];
      wire        fault = link_bit_err_i[p] | ~lk;
      wire        may_fwd = fwd_ctl[p] & lk & (~fwd_ctl[`FWD_GATE_LSB+p] | pass);
      wire        push = hs & ~fault & (fs ? may_fwd : fwd_frame);
      wire [11:0] cur = llen + 12'h001;
      wire        len_bad = le & (lines != 12'h000) & (cur != rlen);
      wire [11:0] nl = lines + {11'h000, le};
      wire        frame_ok = ~bad & ~fault & ~len_bad & ((rlines == 12'h000) | (nl == rlines));

      assign linked[p]        = lk;
      assign passed[p]        = pass;
      // pin needs live pixel clock only in wide high-rate mode
      assign pin_lock[p]      = lk & ((mode != `MODE_RAW12HF) | pa[1]);
      assign cfg_v[8*p+:8]    = cfg;
      assign mode_v[2*p+:2]   = mode;
      assign sts_v[8*p+:8]    = {5'h00, pa[1], pass, lk};

      always @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          ls    <= 2'b00;
          pa    <= 2'b00;
          cfg   <= `RST_LOCK_CFG;
          mode  <= `RST_PORT_MODE;
          lst   <= L_OFF;
          timer <= 9'h000;
        end
        else
        begin
          ls <= {ls[0], link_signal_i[p]};
          pa <= {pa[0], pclk_active_i[p]};
          if (wr_en && wr_mask[p] && wr_addr == `ADDR_LOCK_CFG)
            cfg <= wr_data;
          if (wr_en && wr_mask[p] && wr_addr == `ADDR_PORT_MODE)
            mode <= wr_data[1:0];
          case (lst)
            L_OFF:
            begin
              timer <= 9'h000;
              if (port_ctl[p])
                lst <= L_ACQ;
            end
            L_ACQ:
            begin
              if (!port_ctl[p])
                lst <= L_OFF;
              else if (!ls[1] || err_now)
                timer <= 9'h000;
              else if (tick)
              begin
                if (timer == `LOCK_STABLE_TICKS - 1)
                  lst <= L_LOCK;
                else
                  timer <= timer + 9'h001;
              end
            end
            L_LOCK:
            begin
              timer <= 9'h000;
              if (!port_ctl[p])
                lst <= L_OFF;
              else if (!ls[1] || err_now)
                lst <= L_RELOCK;
            end
            L_RELOCK:
            begin
              if (!port_ctl[p])
                lst <= L_OFF;
              else if (tick)
              begin
                if (timer == `RELOCK_TICKS - 1)
                begin
                  lst   <= L_ACQ;
                  timer <= 9'h000;
                end
                else
                  timer <= timer + 9'h001;
              end
            end
            default: lst <= L_OFF;
          endcase
        end
      end

      always @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          in_frame  <= 1'b0;
          fwd_frame <= 1'b0;
          bad       <= 1'b0;
          llen      <= 12'h000;
          rlen      <= 12'h000;
          lines     <= 12'h000;
          rlines    <= 12'h000;
          good      <= 4'h0;
          pass      <= 1'b0;
        end
        else
        begin
          pass <= lk & (good >= cfg[`CFG_FRAMES_LSB+:4]);
          if (!lk)
          begin
            in_frame  <= 1'b0;
            fwd_frame <= 1'b0;
            good      <= 4'h0;
          end
          else if (hs)
          begin
            if (fs)
            begin
              in_frame  <= 1'b1;
              fwd_frame <= may_fwd & ~fault;
              bad       <= fault;
              llen      <= 12'h001;
              lines     <= 12'h000;
            end
            else if (in_frame)
            begin
              llen <= le ? 12'h000 : cur;
              lines <= nl;
              if (le && lines == 12'h000)
                rlen <= cur;
              if (fault || len_bad)
              begin
                bad       <= 1'b1;
                fwd_frame <= 1'b0;
              end
              if (fe)
              begin
                in_frame  <= 1'b0;
                fwd_frame <= 1'b0;
                rlines    <= nl;
                good      <= frame_ok ? ((good == 4'hF) ? 4'hF : good + 4'h1) : 4'h0;
              end
            end
          end
        end
      end

      stream_fifo #(
        .W  (`VID_W),
        .D  (`FIFO_DEPTH),
        .AW (`FIFO_AW)
      ) u_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (push),
        .in_data_i   ({fe, le, fs, vid_data_i[12*p+:12]}),
        .in_ready_o  (in_rdy),
        .out_valid_o (fwd_valid_o[p]),
        .out_data_o  (fwd_data_o[`VID_W*p+:`VID_W]),
        .out_ready_i (fwd_ready_i[p])
      );
      assign vid_ready_o[p] = in_rdy;
    end
  endgenerate
endmodule

//--- rtl/rx_port_lock_regs.vh
// offsets, fields, reset values and timing counts
`ifndef RX_PORT_LOCK_REGS_VH
`define RX_PORT_LOCK_REGS_VH
`define ADDR_DEV_STS     8'h04
`define ADDR_PORT_CTL    8'h0C
`define ADDR_GPIO_ROUTE  8'h10
`define ADDR_FWD_CTL     8'h20
`define ADDR_PAGE_SEL    8'h4C
`define ADDR_PORT_STS1   8'h4D
`define ADDR_LOCK_CFG    8'h4E
`define ADDR_PORT_MODE   8'h6D
`define ADDR_PORT0_ID    8'hF8
`define ADDR_PORT1_ID    8'hF9
`define RST_PORT_CTL     8'h03
`define RST_FWD_CTL      8'h00
`define RST_PAGE_SEL     8'h01
`define RST_GPIO_ROUTE   8'h00
`define RST_LOCK_CFG     8'h41
`define RST_PORT_MODE    2'h0
`define RST_PORT_ID      7'h00
`define LOCK_SEL_LSB     2
`define PASS_SEL_LSB     4
`define FWD_GATE_LSB     4
`define PAGE_RD_BIT      4
`define CFG_ERRCHK_BIT   0
`define CFG_FRAMES_LSB   4
`define MODE_RAW12HF     2'h2
`define CLK_MHZ          200
`define BACKUP_OSC_MHZ   25
`define BACKUP_DIV       (`CLK_MHZ / `BACKUP_OSC_MHZ)
`define REF_GAP_US       20
`define REF_GAP_CYC      (`REF_GAP_US * `CLK_MHZ)
`define REF_NOM_MHZ      25
`define LOCK_STABLE_US   10
`define LOCK_STABLE_TICKS (`LOCK_STABLE_US * `REF_NOM_MHZ)
`define RELOCK_US        1
`define RELOCK_TICKS     (`RELOCK_US * `REF_NOM_MHZ)
`define VID_W            15
`define FIFO_DEPTH       8
`define FIFO_AW          3
`endif

//--- tb/rx_port_lock_pass_control_checker.sv
// assertions for the receive port block
`timescale 1ns/1ps
module rx_port_lock_pass_control_checker (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        reference_clock_input_i,
  input wire logic        scl_i,
  input wire logic        sda_oe_o,
  input wire logic [1:0]  link_signal_i,
  input wire logic [1:0]  fwd_valid_o,
  input wire logic [29:0] fwd_data_o,
  input wire logic [1:0]  fwd_ready_i,
  input wire logic        lock_o,
  input wire logic        pass_o,
  input wire logic [1:0]  gpio_o,
  input wire logic        ref_external_o
);
  logic [11:0] up0, up1, gap;
  logic        ref_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----
  // unbroken signal time per port, time since last reference edge
  // ----
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      up0   <= 12'h000;
      up1   <= 12'h000;
      gap   <= 12'h000;
      ref_q <= 1'b0;
    end
    else
    begin
      up0   <= link_signal_i[0] ? up0 + {11'h000, ~&up0} : 12'h000;
      up1   <= link_signal_i[1] ? up1 + {11'h000, ~&up1} : 12'h000;
      ref_q <= reference_clock_input_i;
      gap   <= (ref_q != reference_clock_input_i) ? 12'h000 : gap + {11'h000, ~&gap};
    end
  a_link_before_lock: assert property ($rose(gpio_o[0]) |-> up0 >= 12'h76C)
    else $error("port 0 linked early");
  a_loss_drops_link: assert property ((!link_signal_i[0]) [*8] |=> !gpio_o[0])
    else $error("port 0 linked after loss");
  a_pins_need_link: assert property ((link_signal_i == 2'b00) [*8] |=> !lock_o && !pass_o)
    else $error("pin high without link");
  a_pass_after_link: assert property ($rose(pass_o) |-> up0 >= 12'h76C || up1 >= 12'h76C)
    else $error("pass without stable link");
  a_fwd_holds_word: assert property (fwd_valid_o[0] && !fwd_ready_i[0] |=> fwd_valid_o[0] && $stable(fwd_data_o[14:0]))
    else $error("stalled word changed");
  a_fwd_needs_link: assert property ($rose(fwd_valid_o[0]) |-> up0 >= 12'h3E8)
    else $error("forwarding without link");
  a_ref_gap_drops: assert property (gap > 12'hFB4 |-> !ref_external_o)
    else $error("reference kept after gap");
  a_ref_edge_first: assert property ($rose(ref_external_o) |-> gap < 12'h00C)
    else $error("reference usable without edge");
  a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed while clock high");
  cover property ($rose(lock_o));
  cover property ($rose(pass_o));
  cover property (fwd_valid_o[0] && fwd_ready_i[0]);
endmodule
bind rx_port_lock_pass_control rx_port_lock_pass_control_checker chk_u (.*);

//--- tb/rx_port_lock_pass_control_tb.sv
// bench for the receive port lock and pass block
`timescale 1ns/1ps
module rx_port_lock_pass_control_tb;
  logic        clk_i = 1'b0, reset_n_i = 1'b0, ref_clk = 1'b0, ref_en = 1'b1, scl = 1'b1, sda_m = 1'b1;
  logic        sda_oe, lock, pass, ref_ext, k;
  logic [1:0]  link, pclk, err, vv, fs, le, fe, vrdy, fval, gpio;
  logic [1:0]  frdy = 2'b00;
  logic [23:0] vdata;
  logic [29:0] fdata;
  logic [14:0] first_out;
  logic [7:0]  q;
  int          num_errors = 0, n_checks = 0, nw = 0, len;
  localparam logic [7:0] RA [4] = '{8'h0C, 8'h20, 8'h4C, 8'h7F};
  localparam logic [7:0] RV [4] = '{8'h03, 8'h00, 8'h01, 8'h00};
  rx_port_lock_pass_control dut_u (.clk_i, .reset_n_i, .reference_clock_input_i(ref_clk), .scl_i(scl),
    .sda_i(sda_m & ~sda_oe), .sda_o(), .sda_oe_o(sda_oe), .link_signal_i(link), .pclk_active_i(pclk),
    .link_bit_err_i(err), .vid_valid_i(vv), .vid_data_i(vdata), .vid_fs_i(fs), .vid_le_i(le), .vid_fe_i(fe),
    .vid_ready_o(vrdy), .fwd_valid_o(fval), .fwd_data_o(fdata), .fwd_ready_i(frdy), .lock_o(lock),
    .pass_o(pass), .gpio_o(gpio), .ref_external_o(ref_ext));
  serializer_model mdl_u (.clk_i, .vid_ready_i(vrdy), .link_signal_o(link), .pclk_active_o(pclk),
    .link_bit_err_o(err), .vid_valid_o(vv), .vid_data_o(vdata), .vid_fs_o(fs), .vid_le_o(le), .vid_fe_o(fe));
  initial
    forever #2.5 clk_i = ~clk_i;
  initial
    forever #20 ref_clk = ref_clk ^ ref_en;
  always @(posedge clk_i)
    frdy <= #1 {1'b1, 1'(($urandom % 3) != 0)};
  always @(posedge clk_i)
    if (fval[0] && frdy[0])
    begin
      if (nw == 0)
        first_out <= fdata[14:0];
      nw <= nw + 1;
    end
  // ----
  // two-wire register access, ten clocks per clock phase
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    tick(3);
    sda_m = b;
    tick(7);
    scl = 1'b1;
    tick(5);
    r = sda_m & ~sda_oe;
    tick(5);
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] o, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], o[i]);
    bit_io(1'b1, ack);
  endtask
  // b=0 gives a start (scl left low), b=1 a stop (scl left high)
  task automatic cond(input logic b);
    tick(3);
    sda_m = ~b;
    tick(7);
    scl = 1'b1;
    tick(10);
    sda_m = b;
    tick(10);
    scl = b;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cond(0);
    byte_io(8'h60, q, k);
    byte_io(a, q, k);
    byte_io(d, q, k);
    cond(1);
  endtask
  task automatic rd(input logic [7:0] dev, input logic [7:0] a, output logic [7:0] o);
    cond(0);
    byte_io(dev, o, k);
    byte_io(a, o, k);
    cond(0);
    byte_io(dev | 8'h01, o, k);
    byte_io(8'hFF, o, k);
    cond(1);
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk_val(nm, {8'h00, e}, {8'h00, g});
  endtask
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wait_lock(input logic v);
    for (int i = 0; i < 3000 && lock !== v; i++)
      tick(1);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    tick(60000);
    num_errors++;
    stop_test;
  end
  initial
  begin
    void'($urandom(30));
    len = 2 + $urandom % 4;
    tick(16);
    reset_n_i = 1'b1;
    tick(4);
    chk_val("fwd_valid", 16'h0000, 16'(fval));
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h60, RA[i], q);
      chk_reg("reset value", RV[i], q);
    end
    cond(0);
    byte_io(8'hFC, q, k);
    cond(1);
    chk_val("foreign address ack", 16'h0001, 16'(k));
    wait_lock(1'b1);
    chk_val("lock pin", 16'h0001, 16'(lock));
    chk_val("gpio unrouted", 16'h0000, 16'(gpio));
    wr(8'h10, 8'h03);
    chk_val("gpio routed", 16'h0003, 16'(gpio));
    wr(8'hF9, 8'hA4);
    rd(8'hA4, 8'h4D, q);
    chk_reg("port 1 status direct", 8'h01, q);
    rd(8'hA4, 8'h0C, q);
    chk_reg("shared via port address", 8'h03, q);
    rd(8'h60, 8'h4D, q);
    chk_reg("port 0 status paged", 8'h05, q);
    wr(8'h4C, 8'h12);
    rd(8'h60, 8'h4D, q);
    chk_reg("port 1 status paged", 8'h01, q);
    wr(8'h6D, 8'h02);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h0C, 8'(8'h03 | (s << 2)));
      chk_val("lock select", 16'((4'h5 >> s) & 4'h1), 16'(lock));
    end
    wr(8'h6D, 8'h03);
    chk_val("lock pin raw10", 16'h0001, 16'(lock));
    chk_val("gpio linked", 16'h0003, 16'(gpio));
    wr(8'h0C, 8'h03);
    wr(8'h4C, 8'h01);
    mdl_u.send_frame(2, len, -1);
    wr(8'h20, 8'h11);
    for (int f = 0; f < 3; f++)
      mdl_u.send_frame(2, len, -1);
    tick(40);
    chk_val("withheld words", 16'h0000, 16'(nw));
    chk_val("pass pin", 16'h0001, 16'(pass));
    mdl_u.send_frame(2, len, -1);
    tick(40);
    chk_val("forwarded words", 16'(2 * len), 16'(nw));
    chk_val("first word", 16'({3'b001, mdl_u.first_w}), 16'(first_out));
    nw = 0;
    mdl_u.send_frame(2, len, 1);
    tick(40);
    chk_val("truncated", 16'h0001, 16'(nw < 2 * len));
    chk_val("pass after error", 16'h0000, 16'(pass));
    chk_val("lock after error", 16'h0000, 16'(lock));
    wait_lock(1'b1);
    chk_val("relock", 16'h0001, 16'(lock));
    wr(8'h20, 8'h01);
    nw = 0;
    mdl_u.send_frame(2, len, -1);
    tick(40);
    chk_val("resumed words", 16'(2 * len), 16'(nw));
    mdl_u.link_signal_o = 2'b00;
    tick(20);
    chk_val("gpio and lock after loss", 16'h0000, 16'({gpio, lock}));
    mdl_u.link_signal_o = 2'b11;
    ref_en = 1'b0;
    tick(4100);
    chk_val("reference lost", 16'h0000, 16'(ref_ext));
    ref_en = 1'b1;
    tick(20);
    chk_val("reference back", 16'h0001, 16'(ref_ext));
    stop_test;
  end
endmodule

//--- tb/serializer_model.sv
// serializer side: link presence, pixel clock state and port 0 video frames
`timescale 1ns/1ps
module serializer_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  vid_ready_i,
  output logic      [1:0]  link_signal_o,
  output logic      [1:0]  pclk_active_o,
  output logic      [1:0]  link_bit_err_o,
  output logic      [1:0]  vid_valid_o,
  output logic      [23:0] vid_data_o,
  output logic      [1:0]  vid_fs_o,
  output logic      [1:0]  vid_le_o,
  output logic      [1:0]  vid_fe_o
);
  logic [11:0] first_w;
  initial
  begin
    link_signal_o = 2'b11;
    pclk_active_o = 2'b01;
    {link_bit_err_o, vid_valid_o, vid_fs_o, vid_le_o, vid_fe_o} = 10'h000;
    vid_data_o    = 24'h000000;
  end
  // idle data toggles so a stale word never passes for a fresh one
  always @(posedge clk_i)
    vid_data_o <= vid_valid_o[0] ? {~vid_data_o[23:12], vid_data_o[11:0]} : ~vid_data_o;
  task automatic send_frame(input int lines, input int len, input int bad);
    for (int i = 0; i < lines * len; i++)
    begin
      vid_valid_o[0]    = 1'b1;
      vid_data_o[11:0]  = 12'($urandom);
      vid_fs_o[0]       = (i == 0);
      vid_le_o[0]       = (i % len == len - 1);
      vid_fe_o[0]       = (i == lines * len - 1);
      link_bit_err_o[0] = (i == bad);
      if (i == 0)
        first_w = vid_data_o[11:0];
      do
        @(posedge clk_i);
      while (vid_ready_i[0] !== 1'b1);
      #1;
    end
    {vid_valid_o[0], vid_fs_o[0], vid_le_o[0], vid_fe_o[0], link_bit_err_o[0]} = 5'h00;
  endtask
endmodule
